// >>> hw/scp_core_regs.sv
// Purpose: core-domain shadow of the link register array
// Assumes: writes arrive one per toggle edge, spaced by whole bytes
// Notes:   update strobe is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
`include "scp_params.svh"
module scp_core_regs (
  input  wire logic     clk,
  input  wire logic     rst,
  scp_xfer_if.core      xfer,
  output var  logic [8*`SCP_NUM_REGS-1:0] cfg,
  output var  logic     upd
);
  logic tog_s;
  logic tog_d;
  logic hit;

  scp_sync u_tog (
    .clk (clk),
    .rst (rst),
    .d   (xfer.wr_tog),
    .q   (tog_s)
  );

  // edge of the synchronised toggle marks a new write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tog_d <= 1'b0;
    end else begin
      tog_d <= tog_s;
    end
  end
  assign hit = tog_s ^ tog_d;

  // apply strobe from a write of the update register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      upd <= 1'b0;
    end else begin
      upd <= hit && (xfer.wr_idx == `SCP_REG_UPDATE) && xfer.wr_data[`SCP_UPDATE_BIT];
    end
  end

  // one shadow byte per register
  genvar g;
  generate
    for (g = 0; g < `SCP_NUM_REGS; g = g + 1) begin : g_shadow
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          cfg[8*g +: 8] <= `SCP_REG_RESET;
        end else if (hit && (xfer.wr_idx == 4'(g)) && (4'(g) != `SCP_REG_UPDATE)) begin
          cfg[8*g +: 8] <= xfer.wr_data;
        end
      end
    end
  endgenerate
endmodule : scp_core_regs
`default_nettype wire

// >>> hw/scp_params.svh
// Purpose: constants of the serial configuration port
// Assumes: included by bare name from scp_top and scp_core_regs
// Notes:   offsets are register addresses on the serial link
`ifndef SCP_PARAMS_SVH
`define SCP_PARAMS_SVH

// instruction word layout
`define SCP_ADDR_W          15
`define SCP_INSTR_BITS      16
`define SCP_INSTR_LAST      4'hF
`define SCP_RW_BIT          15
`define SCP_BYTE_LAST       4'h7

// register storage
`define SCP_NUM_REGS        16
`define SCP_IDX_W           4
`define SCP_REG_RESET       8'h00

// register offsets
`define SCP_REG_CONFIG      15'h0000
`define SCP_LSB_FIRST_BIT   6
`define SCP_REG_TUNE0       4'h4
`define SCP_REG_PHASE0      4'h8
`define SCP_REG_UPDATE      4'hA
`define SCP_UPDATE_BIT      0

// serial clock limit and its length in core cycles
`define SCP_CORE_PERIOD_PS  4000
`define SCP_SCLK_MAX_MHZ    40
`define SCP_SCLK_MIN_PS     (1000000 / `SCP_SCLK_MAX_MHZ)
`define SCP_SCLK_MIN_CYC    ((`SCP_SCLK_MIN_PS + `SCP_CORE_PERIOD_PS - 1) / `SCP_CORE_PERIOD_PS)

`endif

// >>> hw/scp_pkg.sv
// Purpose: types of the serial configuration port
// Assumes: nothing
// Notes:   one-hot sequencer states
package scp_pkg;
  typedef enum logic [2:0] {
    SCP_ST_INSTR = 3'b001,
    SCP_ST_WRITE = 3'b010,
    SCP_ST_READ  = 3'b100
  } scp_state_t;
endpackage : scp_pkg

// >>> hw/scp_sync.sv
// Purpose: two-flop synchroniser for a single level
// Assumes: input comes from another clock domain
// Notes:   first flop feeds only the second
`timescale 1ns/1ps
`default_nettype none
module scp_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic d,
  output var  logic q
);
  logic meta;

  // plain two-stage chain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : scp_sync
`default_nettype wire

// >>> hw/scp_top.sv
// Purpose: three-wire serial configuration port with register storage
// Assumes: SCLK comes from the host and only runs while CS_N is low
// Notes:   link logic on SCLK, applied settings on CORE_CLK
// Notes:   no rate check on SCLK; the host must keep it within limits
`timescale 1ns/1ps
`default_nettype none
`include "scp_params.svh"
module scp_top (
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic        SCLK,
  input  wire logic        CS_N,
  input  wire logic        SDIO_I,
  output var  logic        SDIO_O,
  output var  logic        SDIO_OE_N,
  output var  logic        LSB_FIRST,
  output var  logic [127:0] CFG_REGS,
  output var  logic [31:0] TUNING_WORD,
  output var  logic [15:0] PHASE_OFFSET
);

  // ------------------------------------------------------------
  // link domain: everything below runs on SCLK
  // ------------------------------------------------------------

  scp_pkg::scp_state_t       state;
  logic [3:0]                bit_cnt;
  logic [15:0]               shift;
  logic [`SCP_ADDR_W-1:0]    addr;
  logic [7:0]                rd_byte;
  logic [7:0]                mem [`SCP_NUM_REGS];
  logic                      seq_rst;
  logic                      lsb_first;
  logic [15:0]               next_shift;
  logic [7:0]                next_byte;
  logic                      instr_done;
  logic                      byte_done;
  logic [`SCP_ADDR_W-1:0]    next_addr;
  logic [`SCP_ADDR_W-1:0]    instr_addr;
  logic                      instr_read;
  logic                      wr_fire;
  logic [7:0]                rd_first;
  logic [7:0]                rd_next;
  scp_pkg::scp_state_t       next_state;
  logic [3:0]                next_bit_cnt;
  logic [7:0]                next_rd_byte;
  logic [`SCP_ADDR_W-1:0]    next_work_addr;
  logic                      next_out;
  logic [`SCP_NUM_REGS-1:0]  wr_hit;

  scp_xfer_if xfer ();

  // sequencer reset while select is high; glitch-free since both are levels
  assign seq_rst = RST | CS_N;

  // bit order comes from the live config register
  assign lsb_first = mem[0][`SCP_LSB_FIRST_BIT];

  // shift direction follows the chosen bit order
  always_comb begin
    if (lsb_first) begin
      next_shift = {SDIO_I, shift[15:1]};
      next_byte  = next_shift[15:8];
    end else begin
      next_shift = {shift[14:0], SDIO_I};
      next_byte  = next_shift[7:0];
    end
  end

  // phase boundaries
  assign instr_done = (state == scp_pkg::SCP_ST_INSTR) && (bit_cnt == `SCP_INSTR_LAST);
  assign byte_done  = (state != scp_pkg::SCP_ST_INSTR) && (bit_cnt == `SCP_BYTE_LAST);

  // instruction fields once the sixteenth bit is in
  assign instr_read = next_shift[`SCP_RW_BIT];
  assign instr_addr = next_shift[`SCP_ADDR_W-1:0];

  // address generator: down for MSB-first, up for LSB-first
  always_comb begin
    if (lsb_first) begin
      next_addr = addr + 15'h0001;
    end else begin
      next_addr = addr - 15'h0001;
    end
  end

  // read view of one address; unmapped and update read zero
  function automatic logic [7:0] rd_val(
    input logic [`SCP_ADDR_W-1:0] a,
    input logic [7:0]             m [`SCP_NUM_REGS]
  );
    logic [7:0] v;
    v = 8'h00;
    if ((a[`SCP_ADDR_W-1:`SCP_IDX_W] == 11'h000) && (a[3:0] != `SCP_REG_UPDATE)) begin
      v = m[a[3:0]];
    end
    return v;
  endfunction : rd_val

  assign rd_first = rd_val(instr_addr, mem);
  assign rd_next  = rd_val(next_addr, mem);

  // next sequencer state: instruction phase, then write or read bytes
  always_comb begin
    next_state = state;
    case (state)
      scp_pkg::SCP_ST_INSTR: begin
        if (instr_done && instr_read) begin
          next_state = scp_pkg::SCP_ST_READ;
        end else if (instr_done) begin
          next_state = scp_pkg::SCP_ST_WRITE;
        end
      end
      scp_pkg::SCP_ST_WRITE: begin
        next_state = scp_pkg::SCP_ST_WRITE;
      end
      scp_pkg::SCP_ST_READ: begin
        next_state = scp_pkg::SCP_ST_READ;
      end
      default: begin
        next_state = scp_pkg::SCP_ST_INSTR;
      end
    endcase
  end

  // state flop; a data phase only ends when select rises or RST asserts
  always_ff @(posedge SCLK or posedge seq_rst) begin
    if (seq_rst) begin
      state <= scp_pkg::SCP_ST_INSTR;
    end else begin
      state <= next_state;
    end
  end

  // bit counter: 16 for the instruction, then 8 per byte
  always_comb begin
    if (instr_done || byte_done) begin
      next_bit_cnt = 4'h0;
    end else begin
      next_bit_cnt = bit_cnt + 4'h1;
    end
  end

  // counter flop, cleared with the sequencer
  always_ff @(posedge SCLK or posedge seq_rst) begin
    if (seq_rst) begin
      bit_cnt <= 4'h0;
    end else begin
      bit_cnt <= next_bit_cnt;
    end
  end

  // input shift register, sampled on the rising edge
  always_ff @(posedge SCLK or posedge seq_rst) begin
    if (seq_rst) begin
      shift <= 16'h0000;
    end else begin
      shift <= next_shift;
    end
  end

  // working address: loaded from instruction, stepped per byte
  always_comb begin
    if (instr_done) begin
      next_work_addr = instr_addr;
    end else if (byte_done) begin
      next_work_addr = next_addr;
    end else begin
      next_work_addr = addr;
    end
  end

  // address flop; a partial byte leaves it where it was
  always_ff @(posedge SCLK or posedge seq_rst) begin
    if (seq_rst) begin
      addr <= 15'h0000;
    end else begin
      addr <= next_work_addr;
    end
  end

  // read byte: fetched at the instruction end and at every byte end
  always_comb begin
    if (instr_done && instr_read) begin
      next_rd_byte = rd_first;
    end else if (byte_done && (state == scp_pkg::SCP_ST_READ)) begin
      next_rd_byte = rd_next;
    end else begin
      next_rd_byte = rd_byte;
    end
  end

  // fetched on a rising edge so the first bit is ready at the next fall
  always_ff @(posedge SCLK or posedge seq_rst) begin
    if (seq_rst) begin
      rd_byte <= 8'h00;
    end else begin
      rd_byte <= next_rd_byte;
    end
  end

  // a write completes at the eighth data bit
  assign wr_fire = byte_done && (state == scp_pkg::SCP_ST_WRITE) &&
                   (addr[`SCP_ADDR_W-1:`SCP_IDX_W] == 11'h000);

  // register array, one flop byte per entry; survives select, cleared only by RST
  genvar r;
  generate
    for (r = 0; r < `SCP_NUM_REGS; r = r + 1) begin : g_mem
      assign wr_hit[r] = wr_fire && (addr[3:0] == 4'(r)) && (4'(r) != `SCP_REG_UPDATE);
      always_ff @(posedge SCLK or posedge RST) begin
        if (RST) begin
          mem[r] <= `SCP_REG_RESET;
        end else if (wr_hit[r]) begin
          mem[r] <= next_byte;
        end
      end
    end
  endgenerate

  // toggle per written byte; the core watches its edges
  always_ff @(posedge SCLK or posedge RST) begin
    if (RST) begin
      xfer.wr_tog <= 1'b0;
    end else if (wr_fire) begin
      xfer.wr_tog <= ~xfer.wr_tog;
    end
  end

  // payload held until the next write, long after the toggle has crossed
  always_ff @(posedge SCLK or posedge RST) begin
    if (RST) begin
      xfer.wr_idx  <= 4'h0;
      xfer.wr_data <= 8'h00;
    end else if (wr_fire) begin
      xfer.wr_idx  <= addr[3:0];
      xfer.wr_data <= next_byte;
    end
  end

  // launch value: bit order picks the position inside the byte
  always_comb begin
    if (lsb_first) begin
      next_out = rd_byte[bit_cnt[2:0]];
    end else begin
      next_out = rd_byte[3'h7 - bit_cnt[2:0]];
    end
  end

  // output enable: driven only in a read data phase, released while deselected
  always_ff @(negedge SCLK or posedge seq_rst) begin
    if (seq_rst) begin
      SDIO_OE_N <= 1'b1;
    end else begin
      SDIO_OE_N <= (state != scp_pkg::SCP_ST_READ);
    end
  end

  // data bit on the falling edge, half a period ahead of the host sample
  always_ff @(negedge SCLK or posedge seq_rst) begin
    if (seq_rst) begin
      SDIO_O <= 1'b0;
    end else begin
      SDIO_O <= next_out;
    end
  end

  // ------------------------------------------------------------
  // core domain: shadow copy and applied settings on CORE_CLK
  // ------------------------------------------------------------

  logic [127:0] cfg;
  logic         upd;
  logic         core_rst_q;
  logic         core_rst;

  // core reset asserts at once but releases on a core edge, never mid-cycle
  scp_sync u_rst (
    .clk (CORE_CLK),
    .rst (RST),
    .d   (1'b1),
    .q   (core_rst_q)
  );
  assign core_rst = ~core_rst_q;

  // shadow copy fed by the write toggle
  scp_core_regs u_regs (
    .clk  (CORE_CLK),
    .rst  (core_rst),
    .xfer (xfer.core),
    .cfg  (cfg),
    .upd  (upd)
  );

  // plain registers follow the shadow one cycle later
  always_ff @(posedge CORE_CLK or posedge core_rst) begin
    if (core_rst) begin
      CFG_REGS <= 128'h0;
    end else begin
      CFG_REGS <= cfg;
    end
  end

  // core copy of the order bit for logic beyond the port
  always_ff @(posedge CORE_CLK or posedge core_rst) begin
    if (core_rst) begin
      LSB_FIRST <= 1'b0;
    end else begin
      LSB_FIRST <= cfg[`SCP_LSB_FIRST_BIT];
    end
  end

  // tuning word waits for the update strobe
  always_ff @(posedge CORE_CLK or posedge core_rst) begin
    if (core_rst) begin
      TUNING_WORD <= 32'h0;
    end else if (upd) begin
      TUNING_WORD <= cfg[8*`SCP_REG_TUNE0 +: 32];
    end
  end

  // phase offset shares the strobe so both settings change together
  always_ff @(posedge CORE_CLK or posedge core_rst) begin
    if (core_rst) begin
      PHASE_OFFSET <= 16'h0;
    end else if (upd) begin
      PHASE_OFFSET <= cfg[8*`SCP_REG_PHASE0 +: 16];
    end
  end

endmodule : scp_top
`default_nettype wire

// >>> hw/scp_xfer_if.sv
// Purpose: carries completed register writes from link to core domain
// Assumes: index and data stay stable while the toggle crosses
// Notes:   one toggle edge per written byte
`timescale 1ns/1ps
`default_nettype none
interface scp_xfer_if;
  logic       wr_tog;
  logic [3:0] wr_idx;
  logic [7:0] wr_data;
  modport link (output wr_tog, output wr_idx, output wr_data);
  modport core (input wr_tog, input wr_idx, input wr_data);
endinterface : scp_xfer_if
`default_nettype wire

// >>> verification/scp_checker.sv
// Purpose: port-level checks of the serial configuration port
// Assumes: sees only the top-level ports
// Notes:   link checks count rising edges since select fell
`timescale 1ns/1ps
`default_nettype none
module scp_checker (
  input wire logic         CORE_CLK,
  input wire logic         RST,
  input wire logic         SCLK,
  input wire logic         CS_N,
  input wire logic         SDIO_I,
  input wire logic         SDIO_O,
  input wire logic         SDIO_OE_N,
  input wire logic         LSB_FIRST,
  input wire logic [127:0] CFG_REGS,
  input wire logic [31:0]  TUNING_WORD,
  input wire logic [15:0]  PHASE_OFFSET
);
  logic [6:0] cnt;
  logic       rd;
  // rising edges in this frame; select high clears it
  always_ff @(posedge SCLK or posedge CS_N or posedge RST) begin
    if (CS_N || RST) cnt <= 7'h00;
    else cnt <= cnt + 7'h01;
  end
  // direction bit is first or last depending on order
  always_ff @(posedge SCLK or posedge RST) begin
    if (RST) rd <= 1'b0;
    else if (!CS_N && cnt == (LSB_FIRST ? 7'h0F : 7'h00)) rd <= SDIO_I;
  end
  sequence s_data_phase;
    cnt > 7'h0F;
  endsequence
  chk_line_released: assert property (@(posedge CORE_CLK) disable iff (RST)
    CS_N |-> SDIO_OE_N) else $error("data line driven while deselected");
  chk_out_parked: assert property (@(posedge CORE_CLK) disable iff (RST)
    CS_N |-> !SDIO_O) else $error("data output not parked");
  chk_instr_quiet: assert property (@(posedge SCLK) disable iff (RST || CS_N)
    (cnt < 7'h10) |-> SDIO_OE_N) else $error("driven during instruction");
  chk_read_drive: assert property (@(posedge SCLK) disable iff (RST || CS_N)
    s_data_phase |-> (SDIO_OE_N == !rd)) else $error("line direction wrong");
  chk_order_follow: assert property (@(posedge CORE_CLK) disable iff (RST)
    $changed(CFG_REGS[6]) |-> ##[0:2] (LSB_FIRST == CFG_REGS[6]))
    else $error("order output lags");
  chk_update_clear: assert property (@(posedge CORE_CLK) disable iff (RST)
    CFG_REGS[87:80] == 8'h00) else $error("update byte stored");
  chk_tune_apply: assert property (@(posedge CORE_CLK) disable iff (RST)
    $changed(TUNING_WORD) |-> (TUNING_WORD == CFG_REGS[63:32]))
    else $error("tuning word not from shadow");
  chk_phase_apply: assert property (@(posedge CORE_CLK) disable iff (RST)
    $changed(PHASE_OFFSET) |-> (PHASE_OFFSET == CFG_REGS[79:64]))
    else $error("phase offset not from shadow");
  chk_tune_waits: assert property (@(posedge CORE_CLK) disable iff (RST)
    $changed(CFG_REGS[63:32]) |-> $stable(TUNING_WORD))
    else $error("tuning word applied early");
endmodule : scp_checker
bind scp_top scp_checker scp_checker_inst (.CORE_CLK(CORE_CLK), .RST(RST), .SCLK(SCLK),
  .CS_N(CS_N), .SDIO_I(SDIO_I), .SDIO_O(SDIO_O), .SDIO_OE_N(SDIO_OE_N),
  .LSB_FIRST(LSB_FIRST), .CFG_REGS(CFG_REGS), .TUNING_WORD(TUNING_WORD),
  .PHASE_OFFSET(PHASE_OFFSET));
`default_nettype wire

// >>> verification/scp_host.sv
// Purpose: serial master model driving the three-wire port
// Assumes: caller picks the bit order the device is set to
// Notes:   clock stands still outside frames, except the edges idle_clk gives while deselected
`timescale 1ns/1ps
`default_nettype none
module scp_host (
  output var  logic SCLK,
  output var  logic CS_N,
  output var  logic SDIO_I,
  input  wire logic SDIO_O,
  input  wire logic SDIO_OE_N
);
  logic hen = 1'b0;
  logic hb = 1'b0;
  initial SCLK = 1'b0;
  initial CS_N = 1'b1;
  // one shared wire; a floating line shows the inverse of the last bit
  assign SDIO_I = !SDIO_OE_N ? SDIO_O : (hen ? hb : !hb);
  // a few edges while deselected, for reset of the link side
  task automatic idle_clk;
    repeat (2) begin
      #3 SCLK = 1'b1;
      #3 SCLK = 1'b0;
    end
  endtask : idle_clk
  // one frame of nb data bits; read bits land in d at their byte place
  task automatic xfer(input logic lsb, input logic [15:0] ins, input int nb,
                      inout logic [47:0] d);
    int i;
    int p;
    CS_N = 1'b0;
    hen = 1'b1;
    for (i = 0; i < 16 + nb; i++) begin
      p = (i < 16) ? (lsb ? i : 15 - i) :
          ((i - 16) / 8) * 8 + (lsb ? (i - 16) % 8 : 7 - (i - 16) % 8);
      if (i >= 16 && ins[15]) hen = 1'b0;
      hb = (i < 16) ? ins[p] : d[p];
      #3;
      if (i >= 16 && ins[15]) d[p] = SDIO_I;
      SCLK = 1'b1;
      #3 SCLK = 1'b0; // bench period fixed by the clock plan, not the host limit
    end
    #3 CS_N = 1'b1;
    #40;
  endtask : xfer
endmodule : scp_host
`default_nettype wire

// >>> verification/scp_tb.sv
// Purpose: self-checking bench of the serial configuration port
// Assumes: host model frames every access
// Notes:   gap after each frame covers the core crossing
`timescale 1ns/1ps
`default_nettype none
module serial_config_port_tb_top;
  logic         core_clk = 1'b0;
  logic         rst = 1'b1;
  logic         sclk, cs_n, sdio_i, sdio_o, sdio_oe_n, lsb_first;
  logic [127:0] cfg;
  logic [31:0]  tune;
  logic [15:0]  phase;
  logic [47:0]  d;
  logic         lsb = 1'b0;
  int           fail_count = 0;
  int           cmp_count = 0;
  // core clock, 4 ns
  always #2 core_clk = ~core_clk;
  scp_top scp_top_inst (.CORE_CLK(core_clk), .RST(rst), .SCLK(sclk), .CS_N(cs_n),
    .SDIO_I(sdio_i), .SDIO_O(sdio_o), .SDIO_OE_N(sdio_oe_n), .LSB_FIRST(lsb_first),
    .CFG_REGS(cfg), .TUNING_WORD(tune), .PHASE_OFFSET(phase));
  scp_host scp_host_inst (.SCLK(sclk), .CS_N(cs_n), .SDIO_I(sdio_i), .SDIO_O(sdio_o),
    .SDIO_OE_N(sdio_oe_n));
  task automatic tally_and_finish;
    if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic sx(input logic [15:0] ins, input int nb);
    scp_host_inst.xfer(lsb, ins, nb, d);
  endtask : sx
  // hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    fork
      scp_host_inst.idle_clk();
    join_none
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk("cfg_reset", 128'h0, cfg);
    chk("order_reset", 128'h0, 128'(lsb_first));
    d = 48'h5A; sx(16'h0003, 8);
    chk("reg3", 128'h5A, 128'(cfg[31:24]));
    d = 48'h0; sx(16'h8003, 8);
    chk("rd_reg3", 128'h5A, 128'(d[7:0]));
    d = 48'hF; sx(16'h0003, 4);
    chk("partial", 128'h5A, 128'(cfg[31:24]));
    d = 48'h665544332211; sx(16'h0009, 48);
    chk("burst_dn", 128'h112233445566, 128'(cfg[79:32]));
    chk("tune_hold", 128'h0, 128'(tune));
    chk("phase_hold", 128'h0, 128'(phase));
    d = 48'h1; sx(16'h000A, 8);
    chk("tune_apply", 128'h33445566, 128'(tune));
    chk("phase_apply", 128'h1122, 128'(phase));
    d = 48'h0; sx(16'h800B, 32);
    chk("rd_burst", 128'h22110000, 128'(d[31:0]));
    d = 48'h3CFF; sx(16'h0010, 16);
    d = 48'h0; sx(16'h8010, 24);
    chk("unmapped", 128'h003C00, 128'(d[23:0]));
    d = 48'h40; sx(16'h0000, 8);
    chk("order_set", 128'h1, 128'(lsb_first));
    lsb = 1'b1;
    d = 48'hB2B1; sx(16'h0001, 16);
    chk("burst_up", 128'hB2B1, 128'(cfg[23:8]));
    d = 48'h0; sx(16'h8001, 16);
    chk("rd_up", 128'hB2B1, 128'(d[15:0]));
    d = 48'h0; sx(16'h0000, 8);
    lsb = 1'b0;
    chk("order_back", 128'h0, 128'(lsb_first));
    tally_and_finish();
  end
endmodule : serial_config_port_tb_top
`default_nettype wire
